// *** verilog/spd_port.sv ***
// Serial data port: bridged-link drop handling, print output, driver control
// Operation
// - Joined ports both use bridged-link mode and the same drop number.
// - With proxy on in bridged-link mode, Ethernet drop keeps the two low decimal digits.
// - Peripheral port accepts routed print requests of its module.
// - Accepted print requests go out as raw ASCII characters on serial.
// - Point-to-point drive: driver always on, receiver always on.
// - Slave drive A: driver follows CTS, high impedance when inactive.
// - Half duplex: driver always on, receiver off while transmitting.
// - Two-wire: driver follows CTS, receiver off while transmitting.
`timescale 1ns/1ps
`default_nettype none
module spd_port
    import spd_pkg::*;
#(
    parameter int DEPTH = spd_pkg::SPD_DEPTH
) (
    input wire logic MCLK, // 10 MHz clock
    input wire logic RST, // Async reset, active high
    input wire logic [3:0] ADDR, // Register index
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [7:0] RDATA, // Read data, cycle after RD
    input wire logic PRN_VALID, // Routed print character valid
    input wire logic [7:0] PRN_DATA, // Print character
    output logic PRN_READY, // Queue can take a character
    input wire logic CTS, // Clear to send, active high
    input wire logic RXD_IN, // Line receive data
    output logic RXD_OUT, // Receive data gated to the port
    output logic TXD, // Transmit data
    output logic TX_OE_N, // Driver enable, low drives the line
    output logic RX_EN // Receiver enabled
);
    import spd_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT} spd_tx_e;

    //----------------------------------------
    // Registers
    //----------------------------------------
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] drop_reg, drop_next;
    logic [15:0] div_reg, div_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    spd_tx_e st_reg, st_next;
    logic [15:0] bcnt_reg, bcnt_next;
    logic [3:0] bits_reg, bits_next;
    logic [10:0] sh_reg, sh_next;
    logic txd_reg, txd_next;
    logic [7:0] mem_q;
    logic [1:0] mode_f, drv_f;
    logic proxy, par_en, par_odd, seven, full, empty, push, pop, busy, par;
    logic [7:0] eth_drop, ch;
    logic [3:0] nbits;

    assign mode_f = ctrl_reg[SPD_CTRL_MODE_LSB +: 2];
    assign drv_f = ctrl_reg[SPD_CTRL_DRV_LSB +: 2];
    assign proxy = ctrl_reg[SPD_CTRL_PROXY_BIT];
    assign par_en = ctrl_reg[SPD_CTRL_PAR_EN_BIT];
    assign par_odd = ctrl_reg[SPD_CTRL_PAR_ODD_BIT];
    assign seven = ctrl_reg[SPD_CTRL_SEVEN_BIT];

    // Announced Ethernet drop: two low decimal digits when proxied in bridged-link mode
    always_comb
    begin
        eth_drop = drop_reg;
        if (proxy && mode_f == SPD_MODE_BRIDGED)
        begin
            eth_drop = drop_reg % SPD_HUNDRED;
        end
    end

    // Queue status; only peripheral mode accepts print data
    assign full = (wptr_reg[AW] != rptr_reg[AW]) &&
                  (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    assign empty = (wptr_reg == rptr_reg);
    assign PRN_READY = !full && (mode_f == SPD_MODE_PERIPH);
    assign push = PRN_VALID && PRN_READY;
    assign pop = (st_reg == ST_IDLE) && !empty;
    assign busy = (st_reg != ST_IDLE) || !empty;

    spd_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_mem (
        .clk(MCLK),
        .we(push),
        .waddr(wptr_reg[AW-1:0]),
        .wdata(PRN_DATA),
        .raddr(rptr_reg[AW-1:0]),
        .rdata(mem_q)
    );

    //----------------------------------------
    // Register port
    //----------------------------------------
    // Register writes and read data
    always_comb
    begin
        ctrl_next = ctrl_reg;
        drop_next = drop_reg;
        div_next = div_reg;
        rdata_next = 8'h00;
        if (WR)
        begin
            case (ADDR)
                SPD_REG_CTRL: ctrl_next = WDATA;
                SPD_REG_DROP: drop_next = WDATA;
                SPD_REG_BAUD: div_next = {WDATA, 8'h00};
                default: ;
            endcase
        end
        if (RD)
        begin
            case (ADDR)
                SPD_REG_CTRL: rdata_next = ctrl_reg;
                SPD_REG_DROP: rdata_next = drop_reg;
                SPD_REG_BAUD: rdata_next = div_reg[15:8];
                SPD_REG_STAT: rdata_next = {5'h00, RX_EN, full, busy};
                SPD_REG_ETHDROP: rdata_next = eth_drop;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Register the port state
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_reg <= SPD_CTRL_RST;
            drop_reg <= SPD_DROP_RST;
            div_reg <= SPD_DIV_RST;
            rdata_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            drop_reg <= drop_next;
            div_reg <= div_next;
            rdata_reg <= rdata_next;
        end
    end
    assign RDATA = rdata_reg;

    //----------------------------------------
    // Transmitter
    //----------------------------------------
    // Frame build: start, 7 or 8 data bits, optional parity, stop
    always_comb
    begin
        ch = seven ? {1'b0, mem_q[6:0]} : mem_q;
        par = (^ch) ^ par_odd;
        nbits = 4'h9 + {3'h0, par_en} - {3'h0, seven};
        st_next = st_reg;
        bcnt_next = bcnt_reg;
        bits_next = bits_reg;
        sh_next = sh_reg;
        txd_next = txd_reg;
        wptr_next = push ? wptr_reg + (AW+1)'(1) : wptr_reg;
        rptr_next = pop ? rptr_reg + (AW+1)'(1) : rptr_reg;
        case (st_reg)
            ST_IDLE:
            begin
                txd_next = 1'b1;
                if (pop)
                begin
                    st_next = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                // Raw ASCII character out of the line
                sh_next = seven ? {1'b1, 1'b1, par, ch[6:0], 1'b0}
                                : {1'b1, par, ch, 1'b0};
                if (!par_en)
                begin
                    sh_next = seven ? {2'h3, 1'b1, ch[6:0], 1'b0}
                                    : {1'b1, 1'b1, ch, 1'b0};
                end
                bits_next = nbits;
                bcnt_next = div_reg;
                txd_next = 1'b0;
                st_next = ST_SHIFT;
            end
            ST_SHIFT:
            begin
                if (bcnt_reg <= 16'h0001)
                begin
                    bcnt_next = div_reg;
                    sh_next = {1'b1, sh_reg[10:1]};
                    txd_next = sh_reg[1];
                    if (bits_reg == 4'h0)
                    begin
                        // Stop bit done: busy ends only now
                        st_next = ST_IDLE;
                        txd_next = 1'b1;
                    end
                    else
                    begin
                        bits_next = bits_reg - 4'h1;
                    end
                end
                else
                begin
                    bcnt_next = bcnt_reg - 16'h0001;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    // Register the transmitter
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            st_reg <= ST_IDLE;
            bcnt_reg <= 16'h0000;
            bits_reg <= 4'h0;
            sh_reg <= 11'h7FF;
            txd_reg <= 1'b1;
            wptr_reg <= '0;
            rptr_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            bcnt_reg <= bcnt_next;
            bits_reg <= bits_next;
            sh_reg <= sh_next;
            txd_reg <= txd_next;
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
        end
    end
    assign TXD = txd_reg;

    //----------------------------------------
    // Driver control
    //----------------------------------------
    // Driver enable and receiver gating by driver mode
    always_comb
    begin
        TX_OE_N = 1'b0;
        RX_EN = 1'b1;
        case (drv_f)
            SPD_DRV_P2P: RX_EN = 1'b1;
            SPD_DRV_SLAVE_A: TX_OE_N = !CTS;
            SPD_DRV_HALF: RX_EN = !busy;
            SPD_DRV_TWO:
            begin
                TX_OE_N = !CTS;
                RX_EN = !busy;
            end
            default: RX_EN = 1'b1;
        endcase
    end
    assign RXD_OUT = RX_EN ? RXD_IN : 1'b1;
endmodule
`default_nettype wire

// *** verilog/spd_pkg.sv ***
// Package of constants for the serial print and driver port
package spd_pkg;
    // Port modes
    typedef enum logic [1:0] {
        SPD_MODE_IDLE,
        SPD_MODE_BRIDGED,
        SPD_MODE_PERIPH
    } spd_mode_e;
    // Driver modes, two-bit field
    localparam logic [1:0] SPD_DRV_P2P = 2'h0;
    localparam logic [1:0] SPD_DRV_SLAVE_A = 2'h1;
    localparam logic [1:0] SPD_DRV_HALF = 2'h2;
    localparam logic [1:0] SPD_DRV_TWO = 2'h3;
    // Register indices on the plain port
    localparam logic [3:0] SPD_REG_CTRL = 4'h0;
    localparam logic [3:0] SPD_REG_DROP = 4'h1;
    localparam logic [3:0] SPD_REG_BAUD = 4'h2;
    localparam logic [3:0] SPD_REG_STAT = 4'h3;
    localparam logic [3:0] SPD_REG_ETHDROP = 4'h4;
    // Control field positions
    localparam int SPD_CTRL_MODE_LSB = 0;
    localparam int SPD_CTRL_DRV_LSB = 2;
    localparam int SPD_CTRL_PROXY_BIT = 4;
    localparam int SPD_CTRL_PAR_EN_BIT = 5;
    localparam int SPD_CTRL_PAR_ODD_BIT = 6;
    localparam int SPD_CTRL_SEVEN_BIT = 7;
    // Reset values
    localparam logic [7:0] SPD_CTRL_RST = 8'h00;
    localparam logic [7:0] SPD_DROP_RST = 8'h00;
    // Baud divisor: 10 MHz / 9600 baud rounded down
    localparam int SPD_CLK_HZ = 10000000;
    localparam int SPD_BAUD_DEF = 9600;
    localparam logic [15:0] SPD_DIV_RST = 16'(SPD_CLK_HZ / SPD_BAUD_DEF);
    localparam logic [7:0] SPD_HUNDRED = 8'h64;
    localparam int SPD_DEPTH = 16;
endpackage

// *** verilog/spd_mem.sv ***
// Character queue memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module spd_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk, // Clock
    input wire logic we, // Write enable
    input wire logic [AW-1:0] waddr, // Write address
    input wire logic [WIDTH-1:0] wdata, // Write data
    input wire logic [AW-1:0] raddr, // Read address
    output logic [WIDTH-1:0] rdata // Registered read data
);
    logic [WIDTH-1:0] mem [DEPTH];
    // Write and registered read
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// *** test/spd_port_asserts.sv ***
// Checker for the serial print and driver port
`timescale 1ns/1ps
`default_nettype none
module spd_port_asserts
    import spd_pkg::*;
(
    input wire logic MCLK, // Clock
    input wire logic RST, // Reset
    input wire logic [3:0] ADDR, // Index
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire logic [7:0] RDATA, // Read data
    input wire logic PRN_READY, // Queue ready
    input wire logic CTS, // Clear to send
    input wire logic RXD_IN, // Line data
    input wire logic RXD_OUT, // Gated data
    input wire logic TXD, // Transmit data
    input wire logic TX_OE_N, // Driver enable
    input wire logic RX_EN // Receiver on
);
logic [7:0] ctl_reg, ctl_next, drop_reg, drop_next, eth;
logic [1:0] drv;
// -------
// Shadow of control and drop
// -------
always_comb
begin
    ctl_next = (WR && ADDR == SPD_REG_CTRL) ? WDATA : ctl_reg;
    drop_next = (WR && ADDR == SPD_REG_DROP) ? WDATA : drop_reg;
end
always_ff @(posedge MCLK or posedge RST)
begin
    if (RST)
    begin
        ctl_reg <= SPD_CTRL_RST;
        drop_reg <= SPD_DROP_RST;
    end
    else
    begin
        ctl_reg <= ctl_next;
        drop_reg <= drop_next;
    end
end
assign drv = ctl_reg[3:2];
assign eth = (ctl_reg[4] && ctl_reg[1:0] == 2'h1) ? drop_reg % SPD_HUNDRED
    : drop_reg;
default clocking cb @(posedge MCLK); endclocking
default disable iff (RST);
property p_p2p; drv == SPD_DRV_P2P |-> !TX_OE_N && RX_EN; endproperty
a_p2p: assert property (p_p2p) else $error("p2p drive");
property p_slv; drv == SPD_DRV_SLAVE_A |-> TX_OE_N == !CTS; endproperty
a_slv: assert property (p_slv) else $error("slave drive");
property p_half; drv == SPD_DRV_HALF |-> !TX_OE_N; endproperty
a_half: assert property (p_half) else $error("half drive");
property p_two; drv == SPD_DRV_TWO |-> TX_OE_N == !CTS; endproperty
a_two: assert property (p_two) else $error("two-wire drive");
property p_rxoff; drv[1] && !TXD |-> !RX_EN; endproperty
a_rxoff: assert property (p_rxoff) else $error("rx on in tx");
property p_echo; RXD_OUT == (RX_EN ? RXD_IN : 1'b1); endproperty
a_echo: assert property (p_echo) else $error("rx gating");
property p_rdy; PRN_READY |-> ctl_reg[1:0] == 2'h2; endproperty
a_rdy: assert property (p_rdy) else $error("ready mode");
property p_eth; RD && ADDR == SPD_REG_ETHDROP |=> RDATA == eth; endproperty
a_eth: assert property (p_eth) else $error("eth drop");
endmodule
bind spd_port spd_port_asserts u_chk (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PRN_READY(PRN_READY),
    .CTS(CTS), .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT), .TXD(TXD),
    .TX_OE_N(TX_OE_N), .RX_EN(RX_EN));
`default_nettype wire

// *** test/spd_far_end.sv ***
// Far-end serial peripheral model: frame decoder, CTS and echo
`timescale 1ns/1ps
`default_nettype none
module spd_far_end (
    input wire logic mclk, // Clock
    input wire logic txd, // Line from the port
    input wire logic tx_oe_n, // Port driver enable
    input wire logic cts_req, // Peripheral ready
    input wire logic [3:0] nbits, // Data bits
    input wire logic par_en, // Parity present
    input wire logic par_odd, // Odd parity
    input wire logic [15:0] div, // Clocks per bit
    output logic cts, // Clear to send
    output logic rxd, // Line back to the port
    output var logic [7:0] rx_byte, // Decoded character
    output var logic rx_ok, // Parity and stop good
    output var logic rx_done // Pulse per frame
);
logic tog = 1'b0;
logic [7:0] sh;
logic pb;
// Echo the line while driven, else a changing pattern
always @(posedge mclk) tog <= !tog;
assign rxd = !tx_oe_n ? txd : tog;
assign cts = cts_req;
// Decode at mid-bit with the format the port is set to
initial
begin
    rx_done = 1'b0;
    forever
    begin
        @(negedge txd);
        repeat (div / 2) @(posedge mclk);
        sh = 8'h00;
        pb = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            repeat (div) @(posedge mclk);
            sh[i] = txd;
        end
        if (par_en)
        begin
            repeat (div) @(posedge mclk);
            pb = txd;
        end
        repeat (div) @(posedge mclk);
        rx_ok = txd && (!par_en || ((^sh ^ pb) == par_odd));
        rx_byte = sh;
        rx_done = 1'b1;
        @(posedge mclk);
        rx_done = 1'b0;
    end
end
endmodule
`default_nettype wire

// *** test/tb_spd_port.sv ***
// Self-checking bench for the serial print and driver port
`timescale 1ns/1ps
`default_nettype none
module tb_spd_port;
import spd_pkg::*;
logic MCLK, RST, WR, RD, PRN_VALID, CTS, RXD_IN, RXD_OUT, TXD, TX_OE_N;
logic RX_EN, PRN_READY, cts_req, par_en, par_odd, rx_ok, rx_done, rd_d;
logic [3:0] ADDR, nbits;
logic [7:0] WDATA, RDATA, PRN_DATA, rx_byte, d;
int error_cnt = 0;
int n_tests = 0;
logic [7:0] rd_q[$], tx_q[$];
spd_port u_dut (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PRN_VALID(PRN_VALID),
    .PRN_DATA(PRN_DATA), .PRN_READY(PRN_READY), .CTS(CTS), .RXD_IN(RXD_IN),
    .RXD_OUT(RXD_OUT), .TXD(TXD), .TX_OE_N(TX_OE_N), .RX_EN(RX_EN));
spd_far_end u_far (.mclk(MCLK), .txd(TXD), .tx_oe_n(TX_OE_N),
    .cts_req(cts_req), .nbits(nbits), .par_en(par_en), .par_odd(par_odd),
    .div(16'h0100), .cts(CTS), .rxd(RXD_IN), .rx_byte(rx_byte),
    .rx_ok(rx_ok), .rx_done(rx_done));
// -------
// Clock, compare and bus tasks
// -------
initial
begin
    MCLK = 1'b0;
    forever #50 MCLK = !MCLK;
end
task summarize;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
endtask
task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
endtask
task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    rd_q.push_back(e);
    @(posedge MCLK);
    RD <= 1'b0;
endtask
task prn(input logic [7:0] v, input logic [7:0] m);
    logic r;
    PRN_VALID <= 1'b1;
    PRN_DATA <= v;
    tx_q.push_back(v & m);
    r = 1'b0;
    while (!r)
    begin
        @(negedge MCLK);
        r = (PRN_READY === 1'b1);
        @(posedge MCLK);
    end
endtask
task drain;
    for (int t = 0; t < 30000 && tx_q.size() != 0; t++) @(posedge MCLK);
    chk(8'(tx_q.size()), 8'h00, "queue left");
    repeat (300) @(posedge MCLK);
endtask
// Read data and decoded frames against the noted results
always @(posedge MCLK)
begin
    rd_d <= RD;
    if (rd_d)
        chk(RDATA, rd_q.pop_front(), "read");
end
always @(posedge rx_done)
begin
    chk({7'h00, rx_ok}, 8'h01, "frame");
    chk(rx_byte, tx_q.pop_front(), "char");
end
initial
begin
    repeat (60000) @(posedge MCLK);
    error_cnt++;
    $display("mismatch at %0t: watchdog", $time);
    summarize;
end
// -------
// Tests
// -------
initial
begin
    {ADDR, WDATA, WR, RD, PRN_VALID, PRN_DATA} = '0;
    {cts_req, par_en, par_odd, nbits} = {3'h4, 4'h8};
    RST = 1'b1;
    d = 8'($urandom(52236));
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    rd(SPD_REG_CTRL, SPD_CTRL_RST);
    rd(SPD_REG_DROP, SPD_DROP_RST);
    rd(4'hF, 8'h00);
    rd(SPD_REG_BAUD, SPD_DIV_RST[15:8]);
    rd(SPD_REG_STAT, 8'h04);
    $display("test reset done");
    // Drop 105 first, then random drops, bridged or peripheral
    for (int i = 0; i < 8; i++)
    begin
        d = (i < 2) ? 8'h69 : 8'($urandom);
        wr(SPD_REG_DROP, d);
        wr(SPD_REG_CTRL, {3'h0, i[0], 2'h0, i[1] ? 2'h2 : 2'h1});
        rd(SPD_REG_ETHDROP, i % 4 == 1 ? d % SPD_HUNDRED : d);
        chk({7'h00, PRN_READY}, {7'h00, i[1]}, "ready");
    end
    $display("test drop done");
    // Every driver mode against both CTS levels
    for (int m = 0; m < 8; m++)
    begin
        wr(SPD_REG_CTRL, {4'h0, m[2:1], 2'h2});
        cts_req <= m[0];
        @(negedge MCLK);
        chk(8'(TX_OE_N), 8'(m[1] && !m[0]), "oe");
    end
    $display("test driver done");
    // Back-to-back characters, 8N1, half duplex
    wr(SPD_REG_BAUD, 8'h01);
    cts_req <= 1'b1;
    wr(SPD_REG_CTRL, 8'h0A);
    for (int k = 0; k < 3; k++) prn(8'($urandom), 8'hFF);
    PRN_VALID <= 1'b0;
    // Receiver must be off while the start bit echoes back
    rd(SPD_REG_STAT, 8'h01);
    @(negedge MCLK);
    chk({7'h00, RXD_OUT}, 8'h01, "echo gated");
    drain;
    rd(SPD_REG_STAT, 8'h04);
    rd(SPD_REG_BAUD, 8'h01);
    // Seven bits, odd parity, two-wire
    {nbits, par_en, par_odd} = {4'h7, 2'h3};
    wr(SPD_REG_CTRL, 8'hEE);
    for (int k = 0; k < 2; k++) prn(8'($urandom), 8'h7F);
    PRN_VALID <= 1'b0;
    drain;
    // Eight bits, even parity, slave drive A
    {nbits, par_en, par_odd} = {4'h8, 2'h2};
    wr(SPD_REG_CTRL, 8'h26);
    prn(8'($urandom), 8'hFF);
    PRN_VALID <= 1'b0;
    drain;
    $display("test print done");
    summarize;
end
endmodule
`default_nettype wire
